// ---- core/ufb_pkg.sv ----
// Package of constants for the fractional baud generator and transmitter.
// Functional notes
// - Oversampling select 00 gives 16X, 01 gives 8X, 10 gives 4X.
// - Sampling clock is input clock over prescaler and divisor; bit rate over oversampling.
// - Integer divisor is high byte 15:8 and low byte 7:0; fraction in sixteenths.
// - In 4X mode odd fractions may jitter bit times by one eighth.
// - Frame is start, data bits, optional parity, then stop bit or bits.
// - Data goes out least significant bit first.
// - With FIFO enabled, holding register writes go into a 64-byte FIFO.
// - Only holding register writes made while holding-ready is high advance the FIFO write pointer.
// - Without FIFO, holding-empty status sets when byte moves to shift register.
// - Holding-empty raises transmit empty interrupt only when its enable is set.
// - Shift-empty status sets only after the shift register fully finishes.
// - Modem control bit 7 selects input clock prescaler of 1 or 4.
// - Four low fraction bits select 0 to 15/16 in sixteenths.
// - Reset divisor is one: low 0x01, high 0x00, fraction 0x00.
package ufb_pkg;
  localparam int UFB_FIFO_DEPTH = 64;
  localparam int UFB_DATA_W = 8;
  localparam logic [7:0] UFB_DIV_LOW_RST = 8'h01;
  localparam logic [7:0] UFB_DIV_HIGH_RST = 8'h00;
  localparam logic [7:0] UFB_DIV_FRAC_RST = 8'h00;
  localparam int UFB_FRAC_LSB = 0;
  localparam int UFB_FRAC_W = 4;
  localparam int UFB_OVS_LSB = 4;
  localparam int UFB_PRESCALE_BIT = 7;
  localparam int UFB_PRESCALE_DIV = 4;
  localparam int UFB_IRQ_THR_EMPTY_BIT = 1;
  localparam int UFB_LS_THR_EMPTY_BIT = 5;
  localparam int UFB_LS_TSR_EMPTY_BIT = 6;
  localparam logic [7:0] UFB_LS_RST = 8'h60;
  localparam logic [7:0] UFB_IRQ_NONE = 8'h01;
  localparam logic [7:0] UFB_IRQ_THR_EMPTY = 8'h02;
  localparam logic [1:0] UFB_OVS_16X = 2'h0;
  localparam logic [1:0] UFB_OVS_8X = 2'h1;
  localparam logic [1:0] UFB_OVS_4X = 2'h2;
  localparam int UFB_OSC_SYNC_STAGES = 2;
  typedef enum logic [2:0] {
    UFB_TX_IDLE,
    UFB_TX_START,
    UFB_TX_DATA,
    UFB_TX_PARITY,
    UFB_TX_STOP
  } ufb_tx_state_e;
endpackage : ufb_pkg

// ---- core/ufb_fifo.sv ----
// Synchronous FIFO with parameterised width and depth and valid/ready sides.
module ufb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic flush_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [$clog2(DEPTH):0] level_out
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least 2.");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic do_wr;
  logic do_rd;
  assign level_out = wr_ptr - rd_ptr;
  // With a power-of-two depth the top level bit alone marks a full FIFO.
  assign wr_ready_out = !level_out[AW];
  assign rd_valid_out = (wr_ptr != rd_ptr);
  assign rd_data_out = mem[rd_ptr[AW-1:0]];
  assign do_wr = wr_valid_in && wr_ready_out;
  assign do_rd = rd_valid_out && rd_ready_in;
  always_ff @(posedge core_clk_in) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= wr_data_in;
    end
  end
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr <= '0;
    end else if (flush_in) begin
      wr_ptr <= '0;
    end else if (do_wr) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_ptr <= '0;
    end else if (flush_in) begin
      rd_ptr <= '0;
    end else if (do_rd) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : ufb_fifo

// ---- core/ufb_tx.sv ----
// Fractional baud generator and serial transmitter of one UART channel.
module ufb_tx
  import ufb_pkg::*;
#(
  parameter int FIFO_DEPTH = UFB_FIFO_DEPTH
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic osc_clock_in,
  input wire logic fifo_enable_in,
  input wire logic fifo_flush_in,
  input wire logic [7:0] modem_control_in,
  input wire logic [7:0] irq_enable_in,
  input wire logic [7:0] divisor_low_byte_in,
  input wire logic divisor_low_byte_we_in,
  input wire logic [7:0] divisor_high_byte_in,
  input wire logic divisor_high_byte_we_in,
  input wire logic [7:0] divisor_fraction_in,
  input wire logic divisor_fraction_we_in,
  input wire logic [1:0] word_length_in,
  input wire logic two_stop_in,
  input wire logic parity_enable_in,
  input wire logic even_parity_in,
  input wire logic [7:0] tx_holding_reg_in,
  input wire logic tx_holding_we_in,
  output logic tx_holding_ready_out,
  output logic [7:0] line_status_out,
  output logic [7:0] irq_status_out,
  output logic irq_out,
  output logic [6:0] tx_level_out,
  output logic sample_tick_out,
  output logic tx_out
);
  // The level port is sized for 64 entries, so other depths are refused.
  if (FIFO_DEPTH != UFB_FIFO_DEPTH) begin : g_bad_depth
    $error("Transmit FIFO depth must stay at 64 bytes.");
  end

  // Divisor registers, written by the host.
  logic [7:0] divisor_low_byte;
  logic [7:0] divisor_high_byte;
  logic [7:0] divisor_fraction;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      divisor_low_byte <= UFB_DIV_LOW_RST;
      divisor_high_byte <= UFB_DIV_HIGH_RST;
      divisor_fraction <= UFB_DIV_FRAC_RST;
    end else begin
      if (divisor_low_byte_we_in) begin
        divisor_low_byte <= divisor_low_byte_in;
      end
      if (divisor_high_byte_we_in) begin
        divisor_high_byte <= divisor_high_byte_in;
      end
      if (divisor_fraction_we_in) begin
        divisor_fraction <= divisor_fraction_in;
      end
    end
  end

  // The oscillator is outside our domain: sync it, then find rising edges.
  // This limits the oscillator to well below half of the core clock.
  logic osc_meta;
  logic osc_sync;
  logic osc_prev;
  logic osc_edge;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_meta <= osc_clock_in;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end
  assign osc_edge = osc_sync && !osc_prev;

  // Prescaler divides the oscillator by 1 or 4.
  logic [1:0] pre_cnt;
  logic pre_tick;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pre_cnt <= '0;
    end else if (osc_edge) begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end
  assign pre_tick = osc_edge && (!modem_control_in[UFB_PRESCALE_BIT] ||
                    pre_cnt == 2'(UFB_PRESCALE_DIV - 1));

  // Divisor counts in sixteenths: each prescaled tick adds 16, and a sample
  // tick fires when the accumulator reaches the full divisor value.
  logic [19:0] div_full;
  logic [19:0] acc;
  logic [19:0] acc_sum;
  logic sample_tick;
  assign div_full = {divisor_high_byte, divisor_low_byte,
    divisor_fraction[UFB_FRAC_LSB +: UFB_FRAC_W]};
  assign acc_sum = acc + 20'h0_0010;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      acc <= '0;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= 1'b0;
      if (divisor_low_byte_we_in || divisor_high_byte_we_in ||
          divisor_fraction_we_in) begin
        // A stale remainder above a smaller new divisor would fire ticks
        // back to back until it drained, so every divisor write restarts.
        acc <= '0;
      end else if (pre_tick) begin
        if (acc_sum >= div_full) begin
          // Remainder carries over; odd fractions jitter bit edges in 8X and 4X modes.
          acc <= acc_sum - div_full;
          sample_tick <= 1'b1;
        end else begin
          acc <= acc_sum;
        end
      end
    end
  end
  assign sample_tick_out = sample_tick;

  // Samples per bit from the oversampling select.
  logic [1:0] ovs_sel;
  logic [4:0] samples_per_bit;
  assign ovs_sel = divisor_fraction[UFB_OVS_LSB +: 2];
  always_comb begin
    unique case (ovs_sel)
      UFB_OVS_8X: samples_per_bit = 5'h08;
      UFB_OVS_4X: samples_per_bit = 5'h04;
      default: samples_per_bit = 5'h10;
    endcase
  end

  // Transmit FIFO; in non-FIFO mode it holds a single byte.
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic fifo_wr_ready;
  logic [6:0] fifo_level;
  logic nf_full;
  ufb_fifo #(.WIDTH(UFB_DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .flush_in(fifo_flush_in),
    .wr_data_in(tx_holding_reg_in),
    .wr_valid_in(tx_holding_we_in && tx_holding_ready_out),
    .wr_ready_out(fifo_wr_ready),
    .rd_data_out(fifo_data),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(fifo_pop),
    .level_out(fifo_level)
  );
  assign nf_full = !fifo_enable_in && fifo_valid;
  assign tx_holding_ready_out = fifo_wr_ready && !nf_full;
  assign tx_level_out = fifo_level;

  // Transmitter state machine.
  ufb_tx_state_e state;
  logic [7:0] tx_shift_reg;
  logic [4:0] sample_cnt;
  logic [2:0] bit_cnt;
  logic parity_acc;
  logic stop_second;
  logic bit_end;
  assign bit_end = sample_tick && (sample_cnt == samples_per_bit - 5'h01);
  assign fifo_pop = (state == UFB_TX_IDLE) && fifo_valid;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= UFB_TX_IDLE;
      tx_shift_reg <= '0;
      sample_cnt <= '0;
      bit_cnt <= '0;
      parity_acc <= 1'b0;
      stop_second <= 1'b0;
      tx_out <= 1'b1;
    end else begin
      if (sample_tick) begin
        sample_cnt <= bit_end ? 5'h00 : sample_cnt + 5'h01;
      end
      unique case (state)
        UFB_TX_IDLE: begin
          tx_out <= 1'b1;
          sample_cnt <= '0;
          if (fifo_valid) begin
            tx_shift_reg <= fifo_data;
            parity_acc <= !even_parity_in;
            state <= UFB_TX_START;
          end
        end
        UFB_TX_START: begin
          tx_out <= 1'b0;
          if (bit_end) begin
            bit_cnt <= '0;
            state <= UFB_TX_DATA;
          end
        end
        UFB_TX_DATA: begin
          tx_out <= tx_shift_reg[0];
          if (bit_end) begin
            parity_acc <= parity_acc ^ tx_shift_reg[0];
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == {1'b1, word_length_in}) begin
              stop_second <= 1'b0;
              state <= parity_enable_in ? UFB_TX_PARITY : UFB_TX_STOP;
            end
          end
        end
        UFB_TX_PARITY: begin
          tx_out <= parity_acc;
          if (bit_end) begin
            state <= UFB_TX_STOP;
          end
        end
        UFB_TX_STOP: begin
          tx_out <= 1'b1;
          if (bit_end) begin
            stop_second <= 1'b1;
            if (!two_stop_in || stop_second) begin
              state <= UFB_TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Status and interrupt.
  logic thr_empty;
  logic tsr_empty;
  assign thr_empty = !fifo_valid;
  assign tsr_empty = thr_empty && (state == UFB_TX_IDLE);
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      line_status_out <= UFB_LS_RST;
      irq_status_out <= UFB_IRQ_NONE;
    end else begin
      line_status_out <= '0;
      line_status_out[UFB_LS_THR_EMPTY_BIT] <= thr_empty;
      line_status_out[UFB_LS_TSR_EMPTY_BIT] <= tsr_empty;
      irq_status_out <= UFB_IRQ_NONE;
      if (thr_empty && irq_enable_in[UFB_IRQ_THR_EMPTY_BIT]) begin
        irq_status_out <= UFB_IRQ_THR_EMPTY;
      end
    end
  end
  assign irq_out = irq_status_out[UFB_IRQ_THR_EMPTY_BIT];
endmodule : ufb_tx

// ---- testbench/ufb_tx_chk.sv ----
// Port assertions for the baud generator and transmitter.
module ufb_tx_chk #(
  parameter int FIFO_DEPTH = 64
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic fifo_enable_in,
  input wire logic [7:0] irq_enable_in,
  input wire logic tx_holding_ready_out,
  input wire logic [7:0] line_status_out,
  input wire logic [7:0] irq_status_out,
  input wire logic irq_out,
  input wire logic [6:0] tx_level_out,
  input wire logic sample_tick_out,
  input wire logic tx_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  chk_irq_mirror: assert property (irq_out == irq_status_out[1])
    else $error("irq pin differs from status");
  chk_irq_gated: assert property (
    irq_status_out[1] |-> $past(irq_enable_in[1])) else $error("irq unmasked");
  chk_irq_codes: assert property (
    irq_status_out == 8'h02 || irq_status_out == 8'h01) else $error("irq code");
  chk_ls_unused: assert property ((line_status_out & 8'h9f) == 8'h00)
    else $error("line status spare bits set");
  chk_tick_gap: assert property (
    sample_tick_out |=> !sample_tick_out [*3]) else $error("tick too close");
  chk_bit_len: assert property (
    $changed(tx_out) |=> $stable(tx_out) [*8]) else $error("bit too short");
  chk_start_busy: assert property (
    $fell(tx_out) |-> ##[0:2] !line_status_out[6]) else $error("shifter idle");
  chk_empty_mark: assert property ($rose(line_status_out[6]) |-> tx_out)
    else $error("empty while line low");
  chk_full_stop: assert property (
    fifo_enable_in && tx_level_out == 7'(FIFO_DEPTH) |-> !tx_holding_ready_out)
    else $error("full fifo accepts");
endmodule : ufb_tx_chk

bind ufb_tx ufb_tx_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (
  .core_clk_in(core_clk_in), .reset_in(reset_in),
  .fifo_enable_in(fifo_enable_in), .irq_enable_in(irq_enable_in),
  .tx_holding_ready_out(tx_holding_ready_out),
  .line_status_out(line_status_out), .irq_status_out(irq_status_out),
  .irq_out(irq_out), .tx_level_out(tx_level_out),
  .sample_tick_out(sample_tick_out), .tx_out(tx_out));

// ---- testbench/ufb_rx_model.sv ----
// Remote receiver model that decodes frames from the serial line.
module ufb_rx_model (
  input wire logic clk_in,
  input wire logic rx_in,
  input wire logic tick_in,
  input wire logic [4:0] bit_ticks_in,
  input wire logic [3:0] nbits_in,
  input wire logic par_en_in,
  input wire logic even_in,
  output logic got_out,
  output logic [7:0] data_out,
  output logic bad_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph = 0;
  int k;
  bit act = 0;
  bit bad;
  logic [7:0] sh;
  initial got_out = 0;
  // Sampling mid-bit tolerates the start edge falling between ticks.
  // The line and tick are read on the falling edge, where they are settled.
  always @(negedge clk_in) begin
    got_out <= 0;
    if (tick_in && !act && !rx_in) begin
      act = 1;
      ph = 1;
      sh = '0;
    end else if (tick_in && act) begin
      k = ph / bit_ticks_in;
      if (ph % bit_ticks_in == bit_ticks_in / 2) begin
        if (k == 0) bad = rx_in;
        else if (k <= nbits_in) sh[k-1] = rx_in;
        else if (par_en_in && k == nbits_in + 1)
          bad = bad | (rx_in != (even_in ? ^sh : ~^sh));
        else begin
          bad = bad | !rx_in;
          act = 0;
          got_out <= 1;
          data_out <= sh;
          bad_out <= bad;
        end
      end
      ph++;
    end
  end
endmodule : ufb_rx_model

// ---- testbench/ufb_tx_tb_top.sv ----
// Self-checking bench for the baud generator and transmitter.
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module ufb_tx_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, osc = 0, fen = 0, flush = 0, we = 0, ts = 0;
  logic pe = 0, ev = 0, dlw = 0, dhw = 0, dfw = 0, rdy, irq, tick, txd;
  logic got, bad;
  logic [7:0] modem_control = 0, irq_enable = 0, dl = 0, dh = 0, df = 0, transmit_holding = 0, ls, irs;
  logic [7:0] rxd;
  logic [6:0] lvl;
  logic [1:0] wl = 2'h3;
  logic [4:0] nt = 5'h10;
  logic [7:0] rq[$];
  int miscompares = 0, cmp_count = 0;
  always #2 clk = ~clk;
  always #16 osc = ~osc;
  ufb_tx dut_u (.core_clk_in(clk), .reset_in(rst), .osc_clock_in(osc),
    .fifo_enable_in(fen), .fifo_flush_in(flush), .modem_control_in(modem_control),
    .irq_enable_in(irq_enable), .divisor_low_byte_in(dl),
    .divisor_low_byte_we_in(dlw), .divisor_high_byte_in(dh),
    .divisor_high_byte_we_in(dhw), .divisor_fraction_in(df),
    .divisor_fraction_we_in(dfw), .word_length_in(wl), .two_stop_in(ts),
    .parity_enable_in(pe), .even_parity_in(ev), .tx_holding_reg_in(transmit_holding),
    .tx_holding_we_in(we), .tx_holding_ready_out(rdy), .line_status_out(ls),
    .irq_status_out(irs), .irq_out(irq), .tx_level_out(lvl),
    .sample_tick_out(tick), .tx_out(txd));
  ufb_rx_model rx_u (.clk_in(clk), .rx_in(txd), .tick_in(tick),
    .bit_ticks_in(nt), .nbits_in(4'(wl) + 4'h5), .par_en_in(pe),
    .even_in(ev), .got_out(got), .data_out(rxd), .bad_out(bad));
  always @(posedge clk) if (got) begin
    rq.push_back(rxd);
    `CHK(bad, 1'b0)
  end
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(logic [7:0] b);
    bit r;
    transmit_holding = b;
    we = 1;
    for (int i = 0; i < 9000; i++) begin
      @(negedge clk) r = rdy;
      @(posedge clk);
      if (r) break;
    end
    `CHK(r, 1'b1)
    #1 we = 0;
    cyc(1);
  endtask : wr
  task automatic wt(logic [7:0] v, int lim);
    for (int i = 0; i < lim && (ls & 8'h60) !== v; i++) cyc(1);
    `CHK(ls & 8'h60, v)
  endtask : wt
  task automatic sdv(logic [7:0] h, l, f);
    {dh, dl, df, dhw, dlw, dfw} = {h, l, f, 3'h7};
    cyc(1);
    {dhw, dlw, dfw} = 3'h0;
    cyc(1);
  endtask : sdv
  task automatic rate(bit w, logic [7:0] h, l, f, m, int e);
    int c = 0, n = 0;
    if (w) sdv(h, l, f);
    modem_control = m;
    for (int i = 0; i < 50000 && n < 18; i++) begin
      @(negedge clk);
      if (n > 1) c++;
      if (tick === 1'b1) n++;
    end
    `CHK(c >= e - 8 && c <= e + 8, 1'b1)
    cyc(1);
  endtask : rate
  task automatic frames();
    for (int i = 0; i < 4; i++) begin
      sdv(8'h00, 8'h01, {2'h0, 2'(i), 4'h0});
      nt = (i == 1) ? 5'h08 : (i == 2) ? 5'h04 : 5'h10;
      {wl, pe, ev, ts} = {2'(i), i[0], i[1], i[0]};
      rq.delete();
      wr(8'ha5 + 8'(i));
      wt(8'h60, 4000);
      `CHK(rq.size(), 1)
      `CHK(rq[0], (8'ha5 + 8'(i)) & (8'hff >> (3 - i)))
    end
  endtask : frames
  task automatic fill(output int n);
    for (n = 0; rdy === 1'b1 && n < 80; n++) wr(8'(n));
  endtask : fill
  task automatic fifo();
    int n;
    {fen, irq_enable, wl, pe, ts} = {1'b1, 8'h02, 2'h3, 2'h0};
    sdv(8'h00, 8'h01, 8'h20);
    nt = 5'h04;
    fill(n);
    `CHK(lvl, 7'h40)
    flush = 1;
    cyc(1);
    flush = 0;
    cyc(1);
    `CHK(lvl, 7'h00)
    wt(8'h60, 2000);
    rq.delete();
    fill(n);
    wt(8'h60, 30000);
    `CHK(rq.size(), n)
    for (int i = 0; i < n; i++) `CHK(rq[i], 8'(i))
    `CHK({irs, irq}, 9'h005)
    irq_enable = 0;
    cyc(2);
    `CHK({irs, irq}, 9'h002)
  endtask : fifo
  task automatic single();
    fen = 0;
    sdv(8'h00, 8'h01, 8'h00);
    nt = 5'h10;
    rq.delete();
    wr(8'h3c);
    wt(8'h20, 400);
    wr(8'hc3);
    `CHK(rdy, 1'b0)
    {transmit_holding, we} = {8'h99, 1'b1};
    cyc(1);
    we = 0;
    wt(8'h60, 4000);
    `CHK(rq.size(), 2)
    `CHK({rq[0], rq[1]}, 16'h3cc3)
  endtask : single
  task automatic end_sim();
    $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  // The longest wait is the full divisor run; the limit allows for it.
  initial begin
    #360000;
    miscompares++;
    end_sim();
  end
  initial begin
    cyc(16);
    rst = 0;
    `CHK({ls, irs, irq, txd}, 18'h18005)
    rate(0, 8'h00, 8'h00, 8'h00, 8'h00, 128);
    rate(1, 8'h00, 8'h02, 8'h00, 8'h00, 256);
    rate(1, 8'h00, 8'h01, 8'h0f, 8'h00, 248);
    rate(1, 8'h00, 8'h01, 8'h00, 8'h80, 512);
    rate(1, 8'h00, 8'h01, 8'h21, 8'h00, 136);
    rate(1, 8'h01, 8'h00, 8'h00, 8'h00, 32768);
    frames();
    fifo();
    single();
    end_sim();
  end
endmodule : ufb_tx_tb_top
